//--- design/rcfm_top.sv
/*
 * record path: per-channel decimator, twelve biquad sections, channel
 * averager / mixer, output fifo, apb register file. fifo in its own module.
 * assumes: modulator bits and frame_sync synchronous to clk_in; one frame
 * lasts at least 20 clocks so that the sequential engine keeps up.
 */
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps

module rcfm_fifo #(
    parameter int WIDTH = 34,
    parameter int DEPTH = 16,
    parameter int LW    = $clog2(DEPTH + 1)
) (
    // clock and reset
    input  wire logic             clk_in,
    input  wire logic             reset_n_in,
    // write side
    input  wire logic             in_valid_in,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  in_ready_out,
    // read side
    output logic                  out_valid_out,
    output logic [WIDTH-1:0]      out_data_out,
    input  wire logic             out_ready_in,
    // fill level
    output logic [LW-1:0]         level_out
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [PW-1:0]    wp_ff, nxt_wp, rp_ff, nxt_rp;
    logic [LW-1:0]    cnt_ff, nxt_cnt;
    logic             ov_ff, nxt_ov;
    logic [WIDTH-1:0] od_ff, nxt_od;
    logic             push, pop;

    always_comb begin
        push    = in_valid_in && (cnt_ff < LW'(DEPTH));
        pop     = (cnt_ff != '0) && (!ov_ff || out_ready_in);
        nxt_wp  = push ? wp_ff + 1'b1 : wp_ff;
        nxt_rp  = pop ? rp_ff + 1'b1 : rp_ff;
        nxt_cnt = cnt_ff + LW'(push) - LW'(pop);
        nxt_ov  = pop ? 1'b1 : (out_ready_in ? 1'b0 : ov_ff);
        nxt_od  = pop ? mem_ff[rp_ff] : od_ff;
    end

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_ff[wp_ff] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wp_ff  <= '0;
            rp_ff  <= '0;
            cnt_ff <= '0;
            ov_ff  <= 1'b0;
            od_ff  <= '0;
        end else begin
            wp_ff  <= nxt_wp;
            rp_ff  <= nxt_rp;
            cnt_ff <= nxt_cnt;
            ov_ff  <= nxt_ov;
            od_ff  <= nxt_od;
        end
    end

    assign in_ready_out  = cnt_ff < LW'(DEPTH);
    assign out_valid_out = ov_ff;
    assign out_data_out  = od_ff;
    assign level_out     = cnt_ff;
endmodule

// Operation
// - twelve programmable two-pole two-zero sections
// - section follows the programmed five-coefficient transfer function
// - reset coefficients give unity-gain pass-through
// - allocation 00 bypasses every section
// - allocation 01: one section per channel
// - allocation 10 (reset): two sections per channel
// - allocation 11: three cascaded sections per channel
// - sections 1-6 page 2, 7-12 page 3
// - summing field resets to off, channels separate
// - summing 01: outputs 1,2 average inputs 1,2
// - mixer active whenever summing is not 01
// - mixer 1 feeds output 1, mixer 2 output 2
// - decimator outputs exactly one sample per frame
// - decimator type field selects three filter kinds
// - default decimator has exactly linear phase
module rcfm_top
    import rcfm_pkg::*;
(
    // clock and reset
    input  wire logic              clk_in,
    input  wire logic              reset_n_in,
    // apb slave
    input  wire logic              psel_in,
    input  wire logic              penable_in,
    input  wire logic              pwrite_in,
    input  wire logic [AW-1:0]     paddr_in,
    input  wire logic [31:0]       pwdata_in,
    output logic [31:0]            prdata_out,
    output logic                   pready_out,
    output logic                   pslverr_out,
    // modulator / pdm bit streams
    input  wire logic [NUM_CH-1:0] mod_data_in,
    input  wire logic              mod_valid_in,
    input  wire logic              frame_sync_in,
    // record samples to the serial port
    output logic [31:0]            smp_data_out,
    output logic [1:0]             smp_chan_out,
    output logic                   smp_valid_out,
    input  wire logic              smp_ready_in
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [31:0]        coef_ff [NUM_WORDS];
    logic [31:0]        nxt_coef [NUM_WORDS];
    logic signed [31:0] hx1_ff [NUM_SEC], hx2_ff [NUM_SEC];
    logic signed [31:0] hy1_ff [NUM_SEC], hy2_ff [NUM_SEC];
    logic signed [31:0] nxt_hx1 [NUM_SEC], nxt_hx2 [NUM_SEC];
    logic signed [31:0] nxt_hy1 [NUM_SEC], nxt_hy2 [NUM_SEC];
    logic signed [31:0] smp_ff [NUM_CH], nxt_smp [NUM_CH];
    logic signed [31:0] deci [NUM_CH];
    logic [1:0]         deci_ff, nxt_deci, sum_ff, nxt_sum, bq_ff, nxt_bq;
    logic               ovr_ff, nxt_ovr;
    rcfm_state_t        st_ff, nxt_st;
    logic [3:0]         idx_ff, nxt_idx;
    logic [31:0]        prdata_ff, nxt_prdata;
    logic               pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
    logic               fifo_ready;
    logic [4:0]         fifo_level;
    // apb decode
    logic               wr_en, coef_hit, reg_hit;
    logic [6:0]         wi;
    logic [1:0]         bl;
    logic [7:0]         rbyte;
    // filter engine
    logic               filt_fire;
    logic signed [31:0] bq_y, mix1, mix2;
    logic               push;

    function automatic logic signed [65:0] ext(input logic [31:0] v);
        return {{34{v[31]}}, v};
    endfunction

    // round to nearest: a unity section then hands samples through unchanged
    localparam logic signed [65:0] HALF_LSB = 66'sh1 <<< (COEF_FRAC - 1);

    // ----------------------------------------------------------------
    // apb register file
    // ----------------------------------------------------------------
    always_comb begin
        int pg;
        int rg;
        int off;
        pg  = int'(paddr_in[AW-1:9]);
        rg  = int'(paddr_in[8:2]);
        off = rg - COEF_REG_FIRST;
        coef_hit = 1'b0;
        wi = '0;
        bl = '0;
        if ((pg == PG_BQ_A || pg == PG_BQ_B) && rg >= COEF_REG_FIRST) begin
            coef_hit = 1'b1;
            wi = 7'(((pg - PG_BQ_A) * SEC_PER_PAGE + off / SEC_REGS) * COEFS_PER_SEC
                    + (off % SEC_REGS) / 4);
            bl = 2'(off % 4);
        end else if (pg == PG_MIX && rg >= COEF_REG_FIRST && rg <= MIX_REG_LAST) begin
            coef_hit = 1'b1;
            wi = 7'(MIX_BASE + off / 4);
            bl = 2'(off % 4);
        end
        reg_hit = coef_hit || (pg == PG_CFG && (rg == REG_ADC_CFG || rg == REG_BQ_CFG
                                               || rg == REG_STATUS));
        rbyte = 8'h00;
        if (coef_hit) begin
            rbyte = coef_ff[wi][8 * (3 - int'(bl)) +: 8];
        end else if (pg == PG_CFG && rg == REG_ADC_CFG) begin
            rbyte[DECI_LSB +: 2] = deci_ff;
            rbyte[SUM_LSB +: 2]  = sum_ff;
        end else if (pg == PG_CFG && rg == REG_BQ_CFG) begin
            rbyte[BQ_LSB +: 2] = bq_ff;
        end else if (pg == PG_CFG && rg == REG_STATUS) begin
            rbyte = {fifo_level, 1'b0, st_ff != ST_IDLE, ovr_ff};
        end
        wr_en       = psel_in && penable_in && pwrite_in && pready_ff && reg_hit;
        nxt_pready  = psel_in && penable_in && !pready_ff;
        nxt_prdata  = nxt_pready ? {24'h000000, rbyte} : prdata_ff;
        nxt_pslverr = nxt_pready ? !reg_hit : 1'b0;
        nxt_deci    = deci_ff;
        nxt_sum     = sum_ff;
        nxt_bq      = bq_ff;
        nxt_ovr     = ovr_ff;
        for (int w = 0; w < NUM_WORDS; w++) begin
            nxt_coef[w] = coef_ff[w];
        end
        if (wr_en && coef_hit) begin
            nxt_coef[wi][8 * (3 - int'(bl)) +: 8] = pwdata_in[7:0];
        end
        if (wr_en && !coef_hit && rg == REG_ADC_CFG) begin
            nxt_deci = pwdata_in[DECI_LSB +: 2];
            nxt_sum  = pwdata_in[SUM_LSB +: 2];
        end
        if (wr_en && !coef_hit && rg == REG_BQ_CFG) begin
            nxt_bq = pwdata_in[BQ_LSB +: 2];
        end
        // clear first so that an overrun in the same cycle still sets
        if (wr_en && !coef_hit && rg == REG_STATUS && pwdata_in[0]) begin
            nxt_ovr = 1'b0;
        end
        if (frame_sync_in && st_ff != ST_IDLE) begin
            nxt_ovr = 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            for (int w = 0; w < NUM_WORDS; w++) begin
                if (w < MIX_BASE) begin
                    coef_ff[w] <= (w % COEFS_PER_SEC == 0) ? COEF_UNITY : COEF_ZERO;
                end else begin
                    coef_ff[w] <= ((w - MIX_BASE) % 5 == 0) ? COEF_UNITY : COEF_ZERO;
                end
            end
            deci_ff    <= DECI_RST;
            sum_ff     <= SUM_RST;
            bq_ff      <= BQ_RST;
            ovr_ff     <= 1'b0;
            prdata_ff  <= '0;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            for (int w = 0; w < NUM_WORDS; w++) begin
                coef_ff[w] <= nxt_coef[w];
            end
            deci_ff    <= nxt_deci;
            sum_ff     <= nxt_sum;
            bq_ff      <= nxt_bq;
            ovr_ff     <= nxt_ovr;
            prdata_ff  <= nxt_prdata;
            pready_ff  <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
        end
    end

    // ----------------------------------------------------------------
    // decimator, one per channel
    // ----------------------------------------------------------------
    for (genvar c = 0; c < NUM_CH; c++) begin : g_deci
        logic signed [15:0] acc_ff, nxt_acc, last_ff, nxt_last;
        logic signed [15:0] step;
        logic signed [33:0] a, b;
        logic signed [31:0] dv;
        always_comb begin
            step     = !mod_valid_in ? 16'sh0000 : (mod_data_in[c] ? 16'sh0001 : -16'sh0001);
            nxt_acc  = frame_sync_in ? step : acc_ff + step;
            nxt_last = frame_sync_in ? acc_ff : last_ff;
            a        = {{2{acc_ff[15]}}, acc_ff, 16'h0000};
            b        = {{2{last_ff[15]}}, last_ff, 16'h0000};
            unique case (deci_ff)
                DECI_LIN:   dv = 32'((a + b) >>> 1);
                DECI_LOW:   dv = 32'((a + a + a + b) >>> 2);
                DECI_ULTRA: dv = 32'(a);
                default:    dv = 32'(a);
            endcase
        end
        assign deci[c] = dv;
        always_ff @(posedge clk_in or negedge reset_n_in) begin
            if (!reset_n_in) begin
                acc_ff  <= '0;
                last_ff <= '0;
            end else begin
                acc_ff  <= nxt_acc;
                last_ff <= nxt_last;
            end
        end
    end

    // ----------------------------------------------------------------
    // sequential engine: biquads, then sum/mix, then fifo push
    // ----------------------------------------------------------------
    always_comb begin
        int k;
        int c;
        k = int'(idx_ff);
        c = int'(idx_ff[1:0]);
        filt_fire = (st_ff == ST_FILT) && (idx_ff[3:2] < bq_ff);
        bq_y = 32'((ext(coef_ff[k * 5]) * ext(smp_ff[c])
                  + 2 * ext(coef_ff[k * 5 + 1]) * ext(hx1_ff[k])
                  + ext(coef_ff[k * 5 + 2]) * ext(hx2_ff[k])
                  + 2 * ext(coef_ff[k * 5 + 3]) * ext(hy1_ff[k])
                  + ext(coef_ff[k * 5 + 4]) * ext(hy2_ff[k])
                  + HALF_LSB) >>> COEF_FRAC);
        mix1 = 32'((ext(coef_ff[MIX_BASE]) * ext(smp_ff[0])
                  + ext(coef_ff[MIX_BASE + 1]) * ext(smp_ff[1])
                  + ext(coef_ff[MIX_BASE + 2]) * ext(smp_ff[2])
                  + ext(coef_ff[MIX_BASE + 3]) * ext(smp_ff[3])
                  + HALF_LSB) >>> COEF_FRAC);
        mix2 = 32'((ext(coef_ff[MIX_BASE + 4]) * ext(smp_ff[0])
                  + ext(coef_ff[MIX_BASE + 5]) * ext(smp_ff[1])
                  + ext(coef_ff[MIX_BASE + 6]) * ext(smp_ff[2])
                  + ext(coef_ff[MIX_BASE + 7]) * ext(smp_ff[3])
                  + HALF_LSB) >>> COEF_FRAC);
        nxt_st  = st_ff;
        nxt_idx = idx_ff;
        push    = 1'b0;
        for (int i = 0; i < NUM_CH; i++) begin
            nxt_smp[i] = smp_ff[i];
        end
        for (int s = 0; s < NUM_SEC; s++) begin
            nxt_hx1[s] = hx1_ff[s];
            nxt_hx2[s] = hx2_ff[s];
            nxt_hy1[s] = hy1_ff[s];
            nxt_hy2[s] = hy2_ff[s];
        end
        unique case (st_ff)
            ST_IDLE: begin
                if (frame_sync_in) begin
                    for (int i = 0; i < NUM_CH; i++) begin
                        nxt_smp[i] = deci[i];
                    end
                    nxt_idx = '0;
                    nxt_st  = ST_FILT;
                end
            end
            ST_FILT: begin
                if (filt_fire) begin
                    nxt_smp[c] = bq_y;
                    nxt_hx1[k] = smp_ff[c];
                    nxt_hx2[k] = hx1_ff[k];
                    nxt_hy1[k] = bq_y;
                    nxt_hy2[k] = hy1_ff[k];
                end
                nxt_idx = idx_ff + 1'b1;
                if (k == NUM_SEC - 1) begin
                    nxt_st = ST_MIX;
                end
            end
            ST_MIX: begin
                if (sum_ff == SUM_AVG) begin
                    nxt_smp[0] = 32'(({smp_ff[0][31], smp_ff[0]}
                                   + {smp_ff[1][31], smp_ff[1]}) >>> 1);
                    nxt_smp[1] = nxt_smp[0];
                end else begin
                    nxt_smp[0] = mix1;
                    nxt_smp[1] = mix2;
                end
                nxt_idx = '0;
                nxt_st  = ST_PUSH;
            end
            ST_PUSH: begin
                push = 1'b1;
                if (fifo_ready) begin
                    nxt_idx = idx_ff + 1'b1;
                    if (idx_ff[1:0] == 2'h3) begin
                        nxt_st = ST_IDLE;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            st_ff  <= ST_IDLE;
            idx_ff <= '0;
            for (int i = 0; i < NUM_CH; i++) begin
                smp_ff[i] <= '0;
            end
            for (int s = 0; s < NUM_SEC; s++) begin
                hx1_ff[s] <= '0;
                hx2_ff[s] <= '0;
                hy1_ff[s] <= '0;
                hy2_ff[s] <= '0;
            end
        end else begin
            st_ff  <= nxt_st;
            idx_ff <= nxt_idx;
            for (int i = 0; i < NUM_CH; i++) begin
                smp_ff[i] <= nxt_smp[i];
            end
            for (int s = 0; s < NUM_SEC; s++) begin
                hx1_ff[s] <= nxt_hx1[s];
                hx2_ff[s] <= nxt_hx2[s];
                hy1_ff[s] <= nxt_hy1[s];
                hy2_ff[s] <= nxt_hy2[s];
            end
        end
    end

    rcfm_fifo #(
        .WIDTH (FIFO_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_in        (clk_in),
        .reset_n_in    (reset_n_in),
        .in_valid_in   (push),
        .in_data_in    ({idx_ff[1:0], smp_ff[idx_ff[1:0]]}),
        .in_ready_out  (fifo_ready),
        .out_valid_out (smp_valid_out),
        .out_data_out  ({smp_chan_out, smp_data_out}),
        .out_ready_in  (smp_ready_in),
        .level_out     (fifo_level)
    );

    assign prdata_out  = prdata_ff;
    assign pready_out  = pready_ff;
    assign pslverr_out = pslverr_ff;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    property p_bypass;
        @(posedge clk_in) disable iff (!reset_n_in)
        (st_ff == ST_FILT && bq_ff == 2'h0) |-> !filt_fire;
    endproperty
    a_bypass: assert property (p_bypass) else $error("section ran while bypassed");

    property p_one_per_ch;
        @(posedge clk_in) disable iff (!reset_n_in)
        (st_ff == ST_FILT && bq_ff == 2'h1) |-> (filt_fire == (idx_ff < 4'h4));
    endproperty
    a_one_per_ch: assert property (p_one_per_ch) else $error("bad 1-section map");

    property p_two_per_ch;
        @(posedge clk_in) disable iff (!reset_n_in)
        (st_ff == ST_FILT && bq_ff == 2'h2) |-> (filt_fire == (idx_ff < 4'h8));
    endproperty
    a_two_per_ch: assert property (p_two_per_ch) else $error("bad 2-section map");

    property p_three_per_ch;
        @(posedge clk_in) disable iff (!reset_n_in)
        (st_ff == ST_FILT && bq_ff == 2'h3) |-> filt_fire;
    endproperty
    a_three_per_ch: assert property (p_three_per_ch) else $error("bad 3-section map");

    property p_avg;
        @(posedge clk_in) disable iff (!reset_n_in)
        (st_ff == ST_MIX && sum_ff == SUM_AVG) |=> (smp_ff[0] == smp_ff[1]);
    endproperty
    a_avg: assert property (p_avg) else $error("averaged outputs differ");

    property p_frame;
        @(posedge clk_in) disable iff (!reset_n_in)
        (frame_sync_in && st_ff == ST_IDLE) |=> (st_ff == ST_FILT) ##12 (st_ff == ST_MIX);
    endproperty
    a_frame: assert property (p_frame) else $error("frame not processed");

    property p_order;
        @(posedge clk_in) disable iff (!reset_n_in)
        $rose(st_ff == ST_PUSH) |-> ($past(st_ff) == ST_MIX);
    endproperty
    a_order: assert property (p_order) else $error("push without mix");

    property p_coef_byte;
        @(posedge clk_in) disable iff (!reset_n_in)
        (wr_en && coef_hit && bl == 2'h0) |=> (coef_ff[$past(wi)][31:24] == $past(pwdata_in[7:0]));
    endproperty
    a_coef_byte: assert property (p_coef_byte) else $error("msb lane not written");

    property p_deci_hold;
        @(posedge clk_in) disable iff (!reset_n_in)
        !wr_en |=> $stable(deci_ff);
    endproperty
    a_deci_hold: assert property (p_deci_hold) else $error("decimator type moved");

    c_three:  cover property (@(posedge clk_in) st_ff == ST_FILT && bq_ff == 2'h3);
    c_avg:    cover property (@(posedge clk_in) st_ff == ST_MIX && sum_ff == SUM_AVG);
    c_stall:  cover property (@(posedge clk_in) st_ff == ST_PUSH && !fifo_ready);
    c_overrun: cover property (@(posedge clk_in) frame_sync_in && st_ff != ST_IDLE);
endmodule

//--- design/rcfm_pkg.sv
/*
 * constants, field layout and state type of the record filter/mixer block.
 * assumes: 32-bit apb, registers byte wide, index = page*128 + register.
 */
package rcfm_pkg;
    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam int AW             = 12;
    localparam int PAGE_REGS      = 128;
    localparam int PG_CFG         = 0;
    localparam int PG_BQ_A        = 2;
    localparam int PG_BQ_B        = 3;
    localparam int PG_MIX         = 4;
    localparam int REG_ADC_CFG    = 107;
    localparam int REG_BQ_CFG     = 108;
    localparam int REG_STATUS     = 120;
    localparam int COEF_REG_FIRST = 8;
    localparam int SEC_REGS       = 20;
    localparam int SEC_PER_PAGE   = 6;
    localparam int MIX_REG_LAST   = 39;
    // ----------------------------------------------------------------
    // fields and reset values
    // ----------------------------------------------------------------
    localparam int DECI_LSB = 4;
    localparam int SUM_LSB  = 2;
    localparam int BQ_LSB   = 5;
    localparam logic [1:0] DECI_RST   = 2'h0;
    localparam logic [1:0] SUM_RST    = 2'h0;
    localparam logic [1:0] BQ_RST     = 2'h2;
    localparam logic [1:0] DECI_LIN   = 2'h0;
    localparam logic [1:0] DECI_LOW   = 2'h1;
    localparam logic [1:0] DECI_ULTRA = 2'h2;
    localparam logic [1:0] SUM_AVG    = 2'h1;
    localparam logic [31:0] COEF_UNITY = 32'h7FFFFFFF;
    localparam logic [31:0] COEF_ZERO  = 32'h00000000;
    // ----------------------------------------------------------------
    // datapath sizes
    // ----------------------------------------------------------------
    localparam int NUM_CH        = 4;
    localparam int NUM_SEC       = 12;
    localparam int COEFS_PER_SEC = 5;
    localparam int MIX_BASE      = 60;
    localparam int NUM_WORDS     = 68;
    localparam int COEF_FRAC     = 31;
    localparam int FIFO_DEPTH    = 16;
    localparam int FIFO_W        = 34;

    typedef enum logic [1:0] {ST_IDLE, ST_FILT, ST_MIX, ST_PUSH} rcfm_state_t;
endpackage

//--- verif/rcfm_sink.sv
/*
 * sample sink standing in for the serial audio port of the record path.
 * assumes: shares clk_in with the block; stall and slow come from the bench.
 */
`timescale 1ns/1ps
module rcfm_sink (
    // clock and reset
    input  wire logic clk_in,
    input  wire logic reset_n_in,
    // bench controls
    input  wire logic stall_in,
    input  wire logic slow_in,
    // sample handshake
    output logic      ready_out
);
    logic [1:0] cnt_ff;
    // slow mode takes one word in four, so the fifo keeps refilling meanwhile
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cnt_ff    <= 2'h0;
            ready_out <= 1'b0;
        end else begin
            cnt_ff    <= cnt_ff + 2'h1;
            ready_out <= !stall_in && (!slow_in || cnt_ff == 2'h3);
        end
    end
endmodule

//--- verif/tb.sv
/*
 * bench for the record filter/mixer: apb tasks, frame driver, sample check.
 * assumes: rcfm_sink on the sample port; one 50 MHz clock.
 */
`timescale 1ns/1ps
module tb;
    import rcfm_pkg::*;
    logic            clk_in = 1'b0, reset_n_in = 1'b0;
    logic            psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [AW-1:0]   paddr = 12'h000;
    logic [31:0]     pwdata = 32'h0, prdata, smp_data;
    logic            pready, pslverr, smp_valid, smp_ready;
    logic [1:0]      smp_chan;
    logic [3:0]      mod_data = 4'h0;
    logic            mod_valid = 1'b0, frame_sync = 1'b0, stall = 1'b0, slow = 1'b0;
    int              bad_count = 0, n_compared = 0, dmode = 2, avg = 1, bq = 0, xh = 0;
    int              cur[4], prev[4];
    logic [34:0]     expq[$];
    logic [34:0]     e;

    always #10 clk_in = ~clk_in;

    rcfm_top dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .mod_data_in(mod_data), .mod_valid_in(mod_valid), .frame_sync_in(frame_sync),
        .smp_data_out(smp_data), .smp_chan_out(smp_chan), .smp_valid_out(smp_valid),
        .smp_ready_in(smp_ready));
    rcfm_sink snk (.clk_in(clk_in), .reset_n_in(reset_n_in), .stall_in(stall),
        .slow_in(slow), .ready_out(smp_ready));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input int idx, input logic [7:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge clk_in);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= AW'(idx * 4);
        pwdata <= {24'h0, wd};
        @(posedge clk_in);
        penable <= 1'b1;
        do begin
            @(posedge clk_in);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input int idx, input logic [7:0] v);
        logic [31:0] r;
        logic        er;
        apb(1'b1, idx, v, r, er);
    endtask
    task automatic rdc(input int idx, input logic [7:0] exp, input logic experr);
        logic [31:0] r;
        logic        er;
        apb(1'b0, idx, 8'h00, r, er);
        chk(r, {24'h0, exp});
        chk({31'h0, er}, {31'h0, experr});
    endtask
    // eight modulator bits, then the frame mark; expectations follow the bench model
    task automatic frame(input logic [3:0] pa, input logic [3:0] pb, input logic keep,
                         input logic cmp);
        int x[4];
        int o[4];
        for (int c = 0; c < 8; c++) begin
            @(posedge clk_in);
            mod_valid <= 1'b1;
            mod_data <= (c < 4) ? pa : pb;
        end
        @(posedge clk_in);
        mod_valid <= 1'b0;
        frame_sync <= 1'b1;
        @(posedge clk_in);
        frame_sync <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            prev[i] = cur[i];
            cur[i] = (pa[i] ? 4 : -4) + (pb[i] ? 4 : -4);
            x[i] = dmode == 0 ? (cur[i] + prev[i]) * 32768 :
                   dmode == 1 ? (3 * cur[i] + prev[i]) * 16384 : cur[i] * 65536;
        end
        o[0] = avg ? (x[0] + x[1]) >>> 1 : x[1] >>> 1;
        o[1] = avg ? (x[0] + x[1]) >>> 1 : x[0] >>> 1;
        o[2] = bq ? (x[2] + xh) >>> 1 : x[2];
        o[3] = x[3];
        if (keep) begin
            xh = x[2];
            for (int i = 0; i < 4; i++) expq.push_back({cmp, 2'(i), 32'(o[i])});
        end
        repeat (22) @(posedge clk_in);
    endtask
    task automatic tally_and_finish;
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    always @(posedge clk_in) begin
        if (smp_valid === 1'b1 && smp_ready === 1'b1) begin
            e = expq.size() > 0 ? expq.pop_front() : {1'b1, 34'bx};
            chk({30'h0, smp_chan}, {30'h0, e[33:32]});
            if (e[34]) chk(smp_data, e[31:0]);
        end
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clk_in);
        reset_n_in <= 1'b1;
        rdc(107, 8'h00, 1'b0);
        rdc(108, 8'h40, 1'b0);
        for (int k = 0; k < 4; k++) rdc(264 + k, k ? 8'hFF : 8'h7F, 1'b0);
        rdc(268, 8'h00, 1'b0);
        rdc(492, 8'h7F, 1'b0);
        rdc(256, 8'h00, 1'b1);
        rdc(619, 8'h00, 1'b1);
        wr(108, 8'hFF);
        rdc(108, 8'h60, 1'b0);
        $display("test reset_and_map done");
        wr(108, 8'h00);
        wr(107, 8'h24);
        frame(4'hF, 4'h5, 1'b1, 1'b1);
        frame(4'h3, 4'hC, 1'b1, 1'b1);
        frame(4'h0, 4'h6, 1'b1, 1'b1);
        wr(108, 8'h40);
        for (int m = 0; m < 2; m++) begin
            wr(107, 8'(m * 16 + 4));
            dmode = m;
            frame(4'hA, 4'h7, 1'b1, 1'b1);
            frame(4'h1, 4'hE, 1'b1, 1'b1);
        end
        $display("test decimator_and_average done");
        wr(107, 8'h20);
        dmode = 2;
        avg = 0;
        wr(108, 8'h60);
        for (int k = 0; k < 4; k++) wr(520 + k, 8'h00);
        wr(524, 8'h40);
        wr(536, 8'h40);
        for (int k = 0; k < 4; k++) wr(540 + k, 8'h00);
        frame(4'h9, 4'h3, 1'b1, 1'b1);
        frame(4'h6, 4'h5, 1'b1, 1'b1);
        $display("test mixer done");
        wr(108, 8'h20);
        wr(304, 8'h40);
        for (int k = 1; k < 4; k++) wr(304 + k, 8'h00);
        wr(308, 8'h20);
        wr(107, 8'h24);
        avg = 1;
        bq = 1;
        frame(4'hB, 4'h0, 1'b1, 1'b0);
        frame(4'hF, 4'h4, 1'b1, 1'b1);
        frame(4'hB, 4'h4, 1'b1, 1'b1);
        frame(4'hF, 4'h0, 1'b1, 1'b1);
        $display("test biquad done");
        stall <= 1'b1;
        for (int f = 0; f < 5; f++) frame(4'hF, 4'h4, 1'b1, 1'b1);
        frame(4'hB, 4'h0, 1'b0, 1'b0);
        rdc(120, 8'h83, 1'b0);
        slow <= 1'b1;
        stall <= 1'b0;
        repeat (150) @(posedge clk_in);
        rdc(120, 8'h01, 1'b0);
        wr(120, 8'h01);
        rdc(120, 8'h00, 1'b0);
        chk(32'(expq.size()), 32'h0);
        $display("test fifo_overrun done");
        tally_and_finish();
    end

    // a hang past about twenty times the expected run length ends the run
    initial begin
        #(20 * 20000);
        bad_count++;
        tally_and_finish();
    end
endmodule
